// ---- isv_arbiter.sv ----
/*
  Fixed-priority pick among maskable requests, lowest index first.
  Assumes the caller supplies in-service state already updated for this cycle.
*/
`timescale 1ns/1ns
module isv_arbiter (
  input  wire logic [isv_pkg::NSRC-1:0] req,
  input  wire logic [isv_pkg::NSRC-1:0] mask,
  input  wire logic [isv_pkg::NSRC-1:0] level,
  input  wire logic [1:0]               in_service_flag,
  output logic [isv_pkg::NSRC-1:0]      elig,
  output logic                          found,
  output logic [2:0]                    idx
);
  import isv_pkg::*;

  // high level needs no high service active; low level needs no service at all
  for (genvar i = 0; i < NSRC; i++) begin : g_elig
    assign elig[i] = req[i] & ~mask[i] & ~in_service_flag[ISP_HI] & (~level[i] | ~in_service_flag[ISP_LO]);
  end

  always_comb begin
    found = 1'b0;
    idx   = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        found = 1'b1;
        idx   = 3'(i);
      end
    end
  end

endmodule

// ---- isv_core_model.sv ----
/*
  Behavioural processor core: acknowledges presented requests and ends services.
  Assumes the block presents requests as levels and samples ack/return pulses.
*/
`timescale 1ns/1ns
module isv_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        int_req,
  input  wire logic [15:0] int_vector,
  input  wire logic        en,
  input  wire logic [7:0]  svc,
  input  wire logic [7:0]  dly,
  output logic             ack,
  output logic             ret,
  output logic             busy,
  output logic [15:0]      last_vec,
  output int               n_ack
);
  logic [7:0] cnt;

  // ==========================================================
  // acknowledge after dly cycles, return svc cycles later
  always_ff @(posedge clk) begin
    if (rst) begin
      ack      <= 1'b0;
      ret      <= 1'b0;
      busy     <= 1'b0;
      cnt      <= 8'h00;
      last_vec <= 16'h0000;
      n_ack    <= 0;
    end else begin
      ack <= 1'b0;
      ret <= 1'b0;
      if (ack && int_req) begin
        last_vec <= int_vector;
        n_ack    <= n_ack + 1;
        busy     <= 1'b1;
        cnt      <= svc;
      end else if (busy) begin
        if (cnt == 8'h00) begin
          ret  <= 1'b1;
          busy <= 1'b0;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end else if (en && int_req && !ret) begin
        // no ack in the return cycle, so the two never coincide
        if (cnt >= dly) begin
          ack <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end else begin
        cnt <= 8'h00;
      end
    end
  end
endmodule

// ---- isv_edge.sv ----
/*
  Edge detector for a timer capture pin.
  Assumes the pin is synchronous to the clock.
*/
`timescale 1ns/1ns
module isv_edge (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            hit
);
  import isv_pkg::*;

  isv_edge_state_t r_ff;
  isv_edge_state_t nxt_r;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.prev = pin;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  always_comb begin
    case (edge_sel)
      EDGE_FALL: hit = r_ff.prev & ~pin;
      EDGE_RISE: hit = ~r_ff.prev & pin;
      EDGE_BOTH: hit = r_ff.prev ^ pin;
      default:   hit = 1'b0;
    endcase
  end

endmodule

// ---- isv_pkg.sv ----
/*
  Shared constants and carrier types for the interrupt source and vector block.
  Assumes a single 10 MHz clock, synchronous active-high reset and an APB master.
*/
package isv_pkg;

  // ==========================================================
  // sources, ranked by default priority (index 0 ranks highest)
  localparam int NSRC = 6;
  localparam logic [2:0] SRC_WDT  = 3'h0;
  localparam logic [2:0] SRC_TM0  = 3'h1;
  localparam logic [2:0] SRC_TM1  = 3'h2;
  localparam logic [2:0] SRC_BUSD = 3'h3;
  localparam logic [2:0] SRC_BUSE = 3'h4;
  localparam logic [2:0] SRC_CONV = 3'h5;
  // default priority of each source, index order
  localparam logic [NSRC-1:0][4:0] PRIO_TABLE = {5'd22, 5'd21, 5'd20, 5'd19, 5'd18, 5'd0};
  localparam logic [NSRC-1:0][15:0] VEC_TABLE =
    {16'h0030, 16'h002E, 16'h002C, 16'h002A, 16'h0028, 16'h0004};
  localparam logic [15:0] VEC_NMI  = 16'h0004;
  localparam logic [15:0] VEC_BRK  = 16'h003E;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  // ==========================================================
  // register map
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_REQ   = 8'h00;
  localparam logic [AW-1:0] OFS_MASK  = 8'h04;
  localparam logic [AW-1:0] OFS_LEVEL = 8'h08;
  localparam logic [AW-1:0] OFS_CTRL  = 8'h0C;
  localparam logic [AW-1:0] OFS_STAT  = 8'h10;
  localparam logic [NSRC-1:0] MASK_RST  = 6'h3F;
  localparam logic [NSRC-1:0] LEVEL_RST = 6'h3F;
  localparam logic [7:0] CTRL_RST = 8'h50;
  // control fields
  localparam int CTL_IE   = 0;
  localparam int CTL_WNMI = 1;
  localparam int CTL_CAP0 = 2;
  localparam int CTL_CAP1 = 3;
  localparam int CTL_EDG0 = 4;
  localparam int CTL_EDG1 = 6;
  // status fields
  localparam int ST_ISP  = 0;
  localparam int ST_NMIP = 2;
  localparam int ST_BRKP = 3;
  localparam int ST_NSRV = 4;
  localparam int ST_REQ  = 5;
  localparam int ST_SRC  = 8;
  localparam int ST_VEC  = 16;
  // in-service bits: high level and low level
  localparam int ISP_HI = 0;
  localparam int ISP_LO = 1;
  // edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {K_NONE, K_NMI, K_BRK, K_MASK} isv_kind_t;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata;
  } isv_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } isv_apb_rsp_t;

  typedef struct packed {
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] mask;
    logic [NSRC-1:0] level;
    logic [7:0]      ctrl;
    logic [1:0]      in_service_flag;
    logic            nmi_pend;
    logic            brk_pend;
    logic            nmi_srv;
    logic            int_req;
    isv_kind_t       kind;
    logic [2:0]      src;
    logic [15:0]     vec;
    logic [31:0]     prdata;
  } isv_state_t;

  typedef struct packed {
    logic prev;
  } isv_edge_state_t;

endpackage

// ---- isv_top.sv ----
/*
  Interrupt source and vector logic: six maskable sources, watchdog non-maskable
  path and the software break, with an APB register slave.
  Assumes all inputs are synchronous to REF_CLK and the core pulses CORE_ACK
  while INT_REQ is high and CORE_RETURN at the end of each service.
*/
// Implementation choices: the APB interface to the registers and the register addresses.
// Functional notes
// - simultaneous maskable requests served by default priority, 0 highest, 22 lowest
// - timer match 0: priority 18, vector 0028H, counter equals compare register 0
// - capture mode: capture pin 0 edge raises timer match 0, same vector
// - timer match 1: priority 19, vector 002AH, compare match or capture pin 1 edge
// - bus data access request raises priority 20, vector 002CH
// - bus error or start/end of communication raises priority 21, vector 002EH
// - conversion done raises priority 22, vector 0030H
// - break instruction raises unmaskable software interrupt through 003EH
// - watchdog selectable non-maskable or maskable, only one type active
// - per-source request, mask, level flags; global enable and in-service flags
// - timer sources use pin path in capture mode, internal path on compare
// - watchdog mode 1 gives non-maskable via 0004H; interval mode priority 0
`timescale 1ns/1ns
module isv_top (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire isv_pkg::isv_apb_req_t APB_REQ,
  output isv_pkg::isv_apb_rsp_t      APB_RSP,
  input  wire logic                  WATCHDOG_IRQ,
  input  wire logic                  TIMER_MATCH0_IRQ,
  input  wire logic                  TIMER_MATCH1_IRQ,
  input  wire logic                  CAPTURE_PIN_0,
  input  wire logic                  CAPTURE_PIN_1,
  input  wire logic                  BUS_DATA_REQUEST_IRQ,
  input  wire logic                  BUS_EVENT_IRQ,
  input  wire logic                  CONVERSION_DONE_IRQ,
  input  wire logic                  BREAK_INSTRUCTION,
  input  wire logic                  CORE_ACK,
  input  wire logic                  CORE_RETURN,
  output logic                       INT_REQ,
  output logic                       INT_NMI,
  output logic [15:0]                INT_VECTOR
);
  import isv_pkg::*;

  // ==========================================================
  // state
  isv_state_t r_ff;
  isv_state_t nxt_r;

  logic            edge0_hit;
  logic            edge1_hit;
  logic            ack_now;
  logic            ack_mask;
  logic            ack_brk;
  logic            ack_nmi;
  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] src_set;
  logic            nmi_set;
  logic [1:0]      isp_after;
  logic            nsrv_after;
  logic            ie_after;
  logic [NSRC-1:0] elig;
  logic            arb_found;
  logic [2:0]      arb_idx;
  logic            apb_setup;
  logic            apb_acc;
  logic            apb_wr;
  logic            addr_hit;
  logic [31:0]     rd_mux;
  logic [NSRC-1:0] mask_after;

  // ==========================================================
  // capture pin edges
  isv_edge u_edge0 (
    .clk      (REF_CLK),
    .rst      (RST),
    .pin      (CAPTURE_PIN_0),
    .edge_sel (r_ff.ctrl[CTL_EDG0 +: 2]),
    .hit      (edge0_hit)
  );

  isv_edge u_edge1 (
    .clk      (REF_CLK),
    .rst      (RST),
    .pin      (CAPTURE_PIN_1),
    .edge_sel (r_ff.ctrl[CTL_EDG1 +: 2]),
    .hit      (edge1_hit)
  );

  // ==========================================================
  // source events
  always_comb begin
    src_set = '0;
    src_set[SRC_WDT] = WATCHDOG_IRQ & ~r_ff.ctrl[CTL_WNMI];
    src_set[SRC_TM0] = r_ff.ctrl[CTL_CAP0] ? edge0_hit : TIMER_MATCH0_IRQ;
    src_set[SRC_TM1] = r_ff.ctrl[CTL_CAP1] ? edge1_hit : TIMER_MATCH1_IRQ;
    src_set[SRC_BUSD] = BUS_DATA_REQUEST_IRQ;
    src_set[SRC_BUSE] = BUS_EVENT_IRQ;
    src_set[SRC_CONV] = CONVERSION_DONE_IRQ;
  end

  // only the selected watchdog type is ever raised
  assign nmi_set = WATCHDOG_IRQ & r_ff.ctrl[CTL_WNMI];

  // ==========================================================
  // acknowledge and return
  assign ack_now  = CORE_ACK & r_ff.int_req;
  assign ack_mask = ack_now & (r_ff.kind == K_MASK);
  assign ack_brk  = ack_now & (r_ff.kind == K_BRK);
  assign ack_nmi  = ack_now & (r_ff.kind == K_NMI);
  assign clr_vec  = ack_mask ? (NSRC'(1) << r_ff.src) : '0;
  assign ie_after = r_ff.ctrl[CTL_IE] & ~(ack_mask | ack_brk);

  // return clears the innermost service; a new acknowledge in the same cycle wins
  always_comb begin
    isp_after  = r_ff.in_service_flag;
    nsrv_after = r_ff.nmi_srv;
    if (CORE_RETURN) begin
      if (r_ff.nmi_srv) begin
        nsrv_after = 1'b0;
      end else if (r_ff.in_service_flag[ISP_HI]) begin
        isp_after[ISP_HI] = 1'b0;
      end else begin
        isp_after[ISP_LO] = 1'b0;
      end
    end
    if (ack_mask) begin
      if (r_ff.level[r_ff.src]) begin
        isp_after[ISP_LO] = 1'b1;
      end else begin
        isp_after[ISP_HI] = 1'b1;
      end
    end
    if (ack_nmi) begin
      nsrv_after = 1'b1;
    end
  end

  // ==========================================================
  // maskable arbitration
  // a mask write of this cycle already counts, so a freshly masked source is never offered
  assign mask_after = (apb_wr && APB_REQ.paddr == OFS_MASK) ? APB_REQ.pwdata[NSRC-1:0] : r_ff.mask;

  isv_arbiter u_arb (
    .req   (r_ff.req & ~clr_vec),
    .mask  (mask_after),
    .level (r_ff.level),
    .in_service_flag   (isp_after),
    .elig  (elig),
    .found (arb_found),
    .idx   (arb_idx)
  );

  // ==========================================================
  // apb decode
  assign apb_setup = APB_REQ.psel & ~APB_REQ.penable;
  assign apb_acc   = APB_REQ.psel & APB_REQ.penable;
  assign apb_wr    = apb_acc & APB_REQ.pwrite;
  assign addr_hit  = (APB_REQ.paddr == OFS_REQ) | (APB_REQ.paddr == OFS_MASK) |
                     (APB_REQ.paddr == OFS_LEVEL) | (APB_REQ.paddr == OFS_CTRL) |
                     (APB_REQ.paddr == OFS_STAT);

  always_comb begin
    rd_mux = '0;
    case (APB_REQ.paddr)
      OFS_REQ:   rd_mux[NSRC-1:0] = r_ff.req;
      OFS_MASK:  rd_mux[NSRC-1:0] = r_ff.mask;
      OFS_LEVEL: rd_mux[NSRC-1:0] = r_ff.level;
      OFS_CTRL:  rd_mux[7:0] = r_ff.ctrl;
      OFS_STAT: begin
        rd_mux[ST_ISP +: 2]  = r_ff.in_service_flag;
        rd_mux[ST_NMIP]      = r_ff.nmi_pend;
        rd_mux[ST_BRKP]      = r_ff.brk_pend;
        rd_mux[ST_NSRV]      = r_ff.nmi_srv;
        rd_mux[ST_REQ]       = r_ff.int_req;
        rd_mux[ST_SRC +: 3]  = r_ff.src;
        rd_mux[ST_VEC +: 16] = r_ff.vec;
      end
      default:   rd_mux = '0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    logic [NSRC-1:0] sw_clr;
    sw_clr = '0;
    nxt_r = r_ff;
    if (apb_wr && APB_REQ.paddr == OFS_REQ) begin
      sw_clr = APB_REQ.pwdata[NSRC-1:0];
    end
    // a new event wins over any clear in the same cycle
    nxt_r.req      = (r_ff.req & ~clr_vec & ~sw_clr) | src_set;
    nxt_r.nmi_pend = (r_ff.nmi_pend & ~ack_nmi) | nmi_set;
    nxt_r.brk_pend = (r_ff.brk_pend & ~ack_brk) | BREAK_INSTRUCTION;
    nxt_r.in_service_flag      = isp_after;
    nxt_r.nmi_srv  = nsrv_after;
    nxt_r.ctrl[CTL_IE] = ie_after;
    if (apb_wr) begin
      case (APB_REQ.paddr)
        OFS_MASK:  nxt_r.mask  = APB_REQ.pwdata[NSRC-1:0];
        OFS_LEVEL: nxt_r.level = APB_REQ.pwdata[NSRC-1:0];
        OFS_CTRL:  nxt_r.ctrl  = APB_REQ.pwdata[7:0];
        default:   nxt_r.ctrl  = nxt_r.ctrl;
      endcase
    end
    if (apb_setup) begin
      nxt_r.prdata = rd_mux;
    end
    // presentation: non-maskable, then break, then maskable by default priority
    nxt_r.int_req = 1'b0;
    nxt_r.kind    = K_NONE;
    nxt_r.src     = 3'h0;
    nxt_r.vec     = VEC_NONE;
    if (nxt_r.nmi_pend && !nsrv_after) begin
      nxt_r.int_req = 1'b1;
      nxt_r.kind    = K_NMI;
      nxt_r.vec     = VEC_NMI;
    end else if (nxt_r.brk_pend) begin
      nxt_r.int_req = 1'b1;
      nxt_r.kind    = K_BRK;
      nxt_r.vec     = VEC_BRK;
    end else if (arb_found && nxt_r.ctrl[CTL_IE]) begin
      nxt_r.int_req = 1'b1;
      nxt_r.kind    = K_MASK;
      nxt_r.src     = arb_idx;
      nxt_r.vec     = VEC_TABLE[arb_idx];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      r_ff       <= '0;
      r_ff.mask  <= MASK_RST;
      r_ff.level <= LEVEL_RST;
      r_ff.ctrl  <= CTRL_RST;
      r_ff.kind  <= K_NONE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================
  // outputs
  assign INT_REQ        = r_ff.int_req;
  assign INT_NMI        = r_ff.kind == K_NMI;
  assign INT_VECTOR     = r_ff.vec;
  assign APB_RSP.prdata  = r_ff.prdata;
  assign APB_RSP.pready  = 1'b1;
  assign APB_RSP.pslverr = apb_acc & ~addr_hit;

  // ==========================================================
  // checks
  logic no_reg_wr;
  assign no_reg_wr = ~apb_wr;

  property p_prio_order;
    @(posedge REF_CLK) disable iff (RST)
    (r_ff.int_req && r_ff.kind == K_MASK) |->
      (($past(elig) & ((NSRC'(1) << r_ff.src) - NSRC'(1))) == '0);
  endproperty
  a_prio_order: assert property (p_prio_order) else $error("lower ranked source presented first");

  property p_tm0_compare;
    @(posedge REF_CLK) disable iff (RST)
    (!r_ff.ctrl[CTL_CAP0] && TIMER_MATCH0_IRQ) |=> r_ff.req[SRC_TM0];
  endproperty
  a_tm0_compare: assert property (p_tm0_compare) else $error("timer match 0 not raised");

  property p_tm0_capture;
    @(posedge REF_CLK) disable iff (RST)
    (r_ff.ctrl[CTL_CAP0] && edge0_hit) |=> r_ff.req[SRC_TM0];
  endproperty
  a_tm0_capture: assert property (p_tm0_capture) else $error("capture edge 0 not raised");

  property p_tm1_vector;
    @(posedge REF_CLK) disable iff (RST)
    (r_ff.int_req && r_ff.kind == K_MASK && r_ff.src == SRC_TM1) |-> (INT_VECTOR == 16'h002A);
  endproperty
  a_tm1_vector: assert property (p_tm1_vector) else $error("timer match 1 vector wrong");

  property p_bus_data;
    @(posedge REF_CLK) disable iff (RST)
    BUS_DATA_REQUEST_IRQ |=> r_ff.req[SRC_BUSD];
  endproperty
  a_bus_data: assert property (p_bus_data) else $error("bus data request lost");

  property p_bus_event;
    @(posedge REF_CLK) disable iff (RST)
    (BUS_EVENT_IRQ && r_ff.ctrl[CTL_IE] && r_ff.in_service_flag == 2'h0 && !r_ff.mask[SRC_BUSE]
     && r_ff.req[SRC_WDT +: 4] == 4'h0 && !r_ff.nmi_pend && !r_ff.brk_pend
     && !WATCHDOG_IRQ && !BREAK_INSTRUCTION && !CORE_ACK && !CORE_RETURN && no_reg_wr)
      |=> ##1 (INT_REQ && INT_VECTOR == 16'h002E);
  endproperty
  a_bus_event: assert property (p_bus_event) else $error("bus event not presented");

  property p_conv_vector;
    @(posedge REF_CLK) disable iff (RST)
    (r_ff.int_req && r_ff.kind == K_MASK && r_ff.src == SRC_CONV) |-> (INT_VECTOR == 16'h0030);
  endproperty
  a_conv_vector: assert property (p_conv_vector) else $error("conversion vector wrong");

  property p_break;
    @(posedge REF_CLK) disable iff (RST)
    (BREAK_INSTRUCTION && !r_ff.nmi_pend && !WATCHDOG_IRQ) |=> ##1 (INT_REQ && INT_VECTOR == VEC_BRK);
  endproperty
  a_break: assert property (p_break) else $error("break not presented");

  property p_wdt_one_type;
    @(posedge REF_CLK) disable iff (RST)
    (WATCHDOG_IRQ && r_ff.ctrl[CTL_WNMI] && !r_ff.req[SRC_WDT]) |=> (r_ff.nmi_pend && !r_ff.req[SRC_WDT]);
  endproperty
  a_wdt_one_type: assert property (p_wdt_one_type) else $error("both watchdog types raised");

  property p_nmi_vector;
    @(posedge REF_CLK) disable iff (RST)
    (r_ff.nmi_pend && !r_ff.nmi_srv && !CORE_ACK) |=> (INT_REQ && INT_NMI && INT_VECTOR == VEC_NMI);
  endproperty
  a_nmi_vector: assert property (p_nmi_vector) else $error("non-maskable watchdog not presented");

  property p_mask_keeps;
    @(posedge REF_CLK) disable iff (RST)
    (r_ff.req[SRC_TM0] && r_ff.mask[SRC_TM0] && no_reg_wr) |=> r_ff.req[SRC_TM0];
  endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("masked request dropped");

  property p_ie_gate;
    @(posedge REF_CLK) disable iff (RST)
    (!r_ff.ctrl[CTL_IE] && no_reg_wr) |=> !(INT_REQ && r_ff.kind == K_MASK);
  endproperty
  a_ie_gate: assert property (p_ie_gate) else $error("maskable presented with enable clear");

  property p_mask_no_ack;
    @(posedge REF_CLK) disable iff (RST)
    ack_mask |-> !r_ff.mask[r_ff.src];
  endproperty
  a_mask_no_ack: assert property (p_mask_no_ack) else $error("masked source acknowledged");

  property p_wdt_maskable;
    @(posedge REF_CLK) disable iff (RST)
    (WATCHDOG_IRQ && !r_ff.ctrl[CTL_WNMI] && !r_ff.nmi_pend) |=> (r_ff.req[SRC_WDT] && !r_ff.nmi_pend);
  endproperty
  a_wdt_maskable: assert property (p_wdt_maskable) else $error("interval watchdog not maskable");

endmodule

// ---- tb_isv_top.sv ----
/*
  Self-checking bench for the interrupt source and vector block.
  Assumes the core model in its own file and a zero-wait APB slave.
*/
`timescale 1ns/1ns
module tb_isv_top;
  import isv_pkg::*;
  logic         REF_CLK, RST, INT_REQ, INT_NMI, ack, ret, busy, core_en, err;
  isv_apb_req_t req;
  isv_apb_rsp_t rsp;
  logic [6:0]   ev;
  logic [1:0]   cap;
  logic [15:0]  INT_VECTOR, last_vec;
  logic [7:0]   svc, dly;
  logic [31:0]  q;
  int           n_ack, n_fail, n_tests, i;
  logic [15:0]  vt [6] = '{16'h0004, 16'h0028, 16'h002A, 16'h002C, 16'h002E, 16'h0030};

  isv_top i_isv_top (.REF_CLK(REF_CLK), .RST(RST), .APB_REQ(req), .APB_RSP(rsp), .WATCHDOG_IRQ(ev[0]),
    .TIMER_MATCH0_IRQ(ev[1]), .TIMER_MATCH1_IRQ(ev[2]), .CAPTURE_PIN_0(cap[0]), .CAPTURE_PIN_1(cap[1]),
    .BUS_DATA_REQUEST_IRQ(ev[3]), .BUS_EVENT_IRQ(ev[4]), .CONVERSION_DONE_IRQ(ev[5]),
    .BREAK_INSTRUCTION(ev[6]), .CORE_ACK(ack), .CORE_RETURN(ret), .INT_REQ(INT_REQ), .INT_NMI(INT_NMI),
    .INT_VECTOR(INT_VECTOR));
  isv_core_model i_isv_core_model (.clk(REF_CLK), .rst(RST), .int_req(INT_REQ), .int_vector(INT_VECTOR),
    .en(core_en), .svc(svc), .dly(dly), .ack(ack), .ret(ret), .busy(busy), .last_vec(last_vec),
    .n_ack(n_ack));

  // ==========================================================
  // helpers
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      close_out();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge REF_CLK);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge REF_CLK);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge REF_CLK);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    tmo(rsp.pready === 1'b1);
    r = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic fire(input logic [6:0] m);
    @(posedge REF_CLK);
    ev <= m;
    @(posedge REF_CLK);
    ev <= 7'h00;
  endtask

  task automatic no_int();
    repeat (4) begin
      @(posedge REF_CLK);
      chk({31'h0, INT_REQ}, 32'h0);
    end
  endtask

  task automatic expect_int(input logic [15:0] v, input logic nmi);
    int k;
    for (k = 0; k < 8 && INT_REQ !== 1'b1; k++) @(posedge REF_CLK);
    tmo(INT_REQ === 1'b1);
    chk({15'h0, INT_NMI, INT_VECTOR}, {15'h0, nmi, v});
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 60 && busy !== 1'b0; k++) @(posedge REF_CLK);
    tmo(busy === 1'b0);
  endtask

  // let the core take one request and compare the vector it got
  task automatic serve(input logic [15:0] v, input logic wret);
    int k, n0;
    n0 = n_ack;
    core_en <= 1'b1;
    for (k = 0; k < 30 && n_ack == n0; k++) @(posedge REF_CLK);
    tmo(n_ack != n0);
    core_en <= 1'b0;
    chk({16'h0, last_vec}, {16'h0, v});
    if (wret) begin
      wait_idle();
    end
  endtask

  // ==========================================================
  // clock, hang guard, main sequence
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  initial begin
    repeat (60000) @(posedge REF_CLK);
    tmo(1'b0);
  end

  initial begin
    RST = 1'b1;
    req = '0;
    ev = 7'h00;
    cap = 2'h0;
    core_en = 1'b0;
    err = 1'b0;
    svc = 8'h03;
    dly = 8'h00;
    n_fail = 0;
    n_tests = 0;
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(OFS_REQ, 32'h0);
    rd(OFS_MASK, 32'h3F);
    rd(OFS_LEVEL, 32'h3F);
    rd(OFS_CTRL, 32'h50);
    rd(OFS_STAT, 32'h0);
    rd(8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    fire(7'h40);
    expect_int(16'h003E, 1'b0);
    serve(16'h003E, 1'b1);
    wr(OFS_CTRL, 32'h52);
    fire(7'h01);
    expect_int(16'h0004, 1'b1);
    serve(16'h0004, 1'b1);
    wr(OFS_CTRL, 32'h51);
    // watchdog and timer match 0 both arrive while masked
    fire(7'h03);
    no_int();
    rd(OFS_REQ, 32'h3);
    wr(OFS_MASK, 32'h0);
    expect_int(16'h0004, 1'b0);
    serve(16'h0004, 1'b1);
    dly <= 8'h04;
    for (i = 1; i < 6; i++) begin
      wr(OFS_CTRL, 32'h51);
      fire(7'h01 << i);
      expect_int(vt[i], 1'b0);
      serve(vt[i], 1'b1);
    end
    dly <= 8'h00;
    fire(7'h2C);
    no_int();
    wr(OFS_MASK, 32'h4);
    wr(OFS_CTRL, 32'h51);
    expect_int(16'h002C, 1'b0);
    rd(OFS_REQ, 32'h2C);
    serve(16'h002C, 1'b1);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h51);
    serve(16'h002A, 1'b1);
    wr(OFS_CTRL, 32'h51);
    serve(16'h0030, 1'b1);
    rd(OFS_REQ, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(OFS_CTRL, 32'h51 | (32'h4 << i));
      fire(7'h02 << i);
      no_int();
      cap[i] <= 1'b1;
      expect_int(vt[i + 1], 1'b0);
      serve(vt[i + 1], 1'b1);
      cap[i] <= 1'b0;
      wr(OFS_CTRL, 32'h51);
      cap[i] <= 1'b1;
      no_int();
      cap[i] <= 1'b0;
    end
    // capture pin 0 with both edges, falling edge only, and no edge selected
    wr(OFS_CTRL, 32'h65);
    cap[0] <= 1'b1;
    expect_int(16'h0028, 1'b0);
    serve(16'h0028, 1'b1);
    wr(OFS_CTRL, 32'h65);
    cap[0] <= 1'b0;
    expect_int(16'h0028, 1'b0);
    serve(16'h0028, 1'b1);
    wr(OFS_CTRL, 32'h45);
    cap[0] <= 1'b1;
    no_int();
    cap[0] <= 1'b0;
    expect_int(16'h0028, 1'b0);
    serve(16'h0028, 1'b1);
    wr(OFS_CTRL, 32'h75);
    cap[0] <= 1'b1;
    no_int();
    cap[0] <= 1'b0;
    no_int();
    wr(OFS_LEVEL, 32'h0);
    wr(OFS_CTRL, 32'h51);
    svc <= 8'h1E;
    fire(7'h20);
    expect_int(16'h0030, 1'b0);
    serve(16'h0030, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0, q);
    chk(q & 32'h3, 32'h1);
    wr(OFS_CTRL, 32'h51);
    fire(7'h02);
    no_int();
    wait_idle();
    expect_int(16'h0028, 1'b0);
    svc <= 8'h03;
    serve(16'h0028, 1'b1);
    close_out();
  end
endmodule
